/* cpie_pkg.sv */
// Package for the core and peripheral interrupt enable block.
// Assumes an Avalon-MM slave with 32-bit data, one register per word.
package cpie_pkg;
    // Printed offsets are not all multiples of four: byte address = 4 * index
    localparam logic [8:0] IDX_ICS_B0  = 9'h00b;
    localparam logic [8:0] IDX_ICS_B1  = 9'h08b;
    localparam logic [8:0] IDX_ICS_B2  = 9'h10b;
    localparam logic [8:0] IDX_ICS_B3  = 9'h18b;
    localparam logic [8:0] IDX_PIE     = 9'h08c;
    localparam logic [8:0] IDX_PFLAG   = 9'h1f0;
    localparam logic [8:0] IDX_IRQ_ST  = 9'h1f1;
    localparam logic [8:0] IDX_IRQ_MSK = 9'h1f2;
    localparam int         ADDR_W      = 11;

    // Control/status bit positions
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_GROUP_EN  = 6;
    localparam int BIT_TIMER0_EN = 5;
    localparam int BIT_EXIE      = 4;
    localparam int BIT_PORTB_EN  = 3;
    localparam int BIT_T0F  = 2;
    localparam int BIT_EXF  = 1;
    localparam int BIT_RBF  = 0;

    // Peripheral enable bit positions
    localparam int BIT_PSP  = 7;
    localparam int BIT_ADC  = 6;
    localparam int BIT_RX   = 5;
    localparam int BIT_TX   = 4;
    localparam int BIT_SSP  = 3;
    localparam int BIT_CCP1 = 2;
    localparam int BIT_TMR2 = 1;
    localparam int BIT_TMR1 = 0;

    localparam logic [7:0]  ICS_RESET   = 8'h00;
    localparam logic [7:0]  PIE_RESET   = 8'h00;
    localparam logic [7:0]  PFLAG_RESET = 8'h00;
    localparam logic [1:0]  IRQ_RESET   = 2'h0;
    localparam int          IRQ_EV_CORE = 0;
    localparam int          IRQ_EV_PERI = 1;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
endpackage

/* cpie_regbus_if.sv */
// Register access carrier between the bus slave and the interrupt core.
// Assumes one clock domain; write pulses last one cycle.
`timescale 1ns/1ps
`default_nettype none
interface cpie_regbus_if;
    logic       wr_ics;
    logic       wr_pie;
    logic       wr_pflag;
    logic [7:0] wdata;
    logic [7:0] ics;
    logic [7:0] pie;
    logic [7:0] pflag;
    logic       core_event;
    logic       peri_event;

    modport ctrl (
        output wr_ics,
        output wr_pie,
        output wr_pflag,
        output wdata,
        input  ics,
        input  pie,
        input  pflag,
        input  core_event,
        input  peri_event
    );
    modport core (
        input  wr_ics,
        input  wr_pie,
        input  wr_pflag,
        input  wdata,
        output ics,
        output pie,
        output pflag,
        output core_event,
        output peri_event
    );
endinterface
`default_nettype wire

/* cpie_core.sv */
// Interrupt enable/flag storage and request gating.
// Assumes pin and peripheral events already synchronised to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module cpie_core (
    input  wire logic   clk_sys,
    input  wire logic   rst,
    input  wire logic   timer0_ovf,
    input  wire logic   ext_irq_event,
    input  wire logic   portb_change,
    input  wire logic [7:0] peri_cond,
    cpie_regbus_if.core rb,
    output logic        irq_req
);
    logic [7:0] ics_reg;
    logic [7:0] ics_next;
    logic [7:0] pie_reg;
    logic [7:0] pflag_reg;
    logic [7:0] pflag_next;
    logic [2:0] core_set;
    logic [2:0] core_en;
    logic [2:0] core_flag;
    logic       core_pend;
    logic       peri_pend;

    assign core_set = {timer0_ovf, ext_irq_event, portb_change};
    assign core_en  = {ics_reg[cpie_pkg::BIT_TIMER0_EN], ics_reg[cpie_pkg::BIT_EXIE],
                       ics_reg[cpie_pkg::BIT_PORTB_EN]};
    assign core_flag = {ics_reg[cpie_pkg::BIT_T0F], ics_reg[cpie_pkg::BIT_EXF],
                        ics_reg[cpie_pkg::BIT_RBF]};

    // Flags set regardless of enables; set beats a software write of zero
    always_comb begin
        ics_next = rb.wr_ics ? rb.wdata : ics_reg;
        ics_next[cpie_pkg::BIT_T0F] = ics_next[cpie_pkg::BIT_T0F] | core_set[2];
        ics_next[cpie_pkg::BIT_EXF] = ics_next[cpie_pkg::BIT_EXF] | core_set[1];
        ics_next[cpie_pkg::BIT_RBF] = ics_next[cpie_pkg::BIT_RBF] | core_set[0];
    end

    assign pflag_next = (rb.wr_pflag ? rb.wdata : pflag_reg) | peri_cond;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ics_reg   <= cpie_pkg::ICS_RESET;
            pie_reg   <= cpie_pkg::PIE_RESET;
            pflag_reg <= cpie_pkg::PFLAG_RESET;
        end else begin
            ics_reg   <= ics_next;
            pflag_reg <= pflag_next;
            if (rb.wr_pie) begin
                pie_reg <= rb.wdata;
            end
        end
    end

    assign core_pend = |(core_en & core_flag);
    // Bits 7..0: parallel port, adc, rx, tx, ssp, ccp1, timer2 match, timer1 ovf
    assign peri_pend = ics_reg[cpie_pkg::BIT_GROUP_EN] & (|(pie_reg & pflag_reg));
    assign irq_req   = ics_reg[cpie_pkg::BIT_GLOBAL_EN] & (core_pend | peri_pend);

    assign rb.ics        = ics_reg;
    assign rb.pie        = pie_reg;
    assign rb.pflag      = pflag_reg;
    assign rb.core_event = |core_set;
    assign rb.peri_event = |peri_cond;
endmodule
`default_nettype wire

/* cpie_top.sv */
// Core and peripheral interrupt enables with Avalon-MM register access.
// Assumes pins are asynchronous; peripheral conditions come from clk_sys logic.
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module cpie_top (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [10:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        timer0_ovf,
    input  wire logic        ext_irq_pin,
    input  wire logic        ext_irq_rising,
    input  wire logic [3:0]  portb_upper_pins,
    input  wire logic [7:0]  peri_cond,
    output logic             irq_req,
    output logic             irq
);
    cpie_regbus_if rb ();

    // Pin synchronisers
    logic [4:0] pin_meta_reg;
    logic [4:0] pin_sync_reg;
    logic [4:0] pin_prev_reg;
    logic       ext_event;
    logic       portb_event;
    logic       ext_rise;
    logic       ext_fall;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_meta_reg <= 5'h00;
            pin_sync_reg <= 5'h00;
            pin_prev_reg <= 5'h00;
        end else begin
            pin_meta_reg <= {ext_irq_pin, portb_upper_pins};
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    assign ext_rise    = pin_sync_reg[4] & ~pin_prev_reg[4];
    assign ext_fall    = ~pin_sync_reg[4] & pin_prev_reg[4];
    assign ext_event   = ext_irq_rising ? ext_rise : ext_fall;
    assign portb_event = |(pin_sync_reg[3:0] ^ pin_prev_reg[3:0]);

    cpie_core u_core (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .timer0_ovf    (timer0_ovf),
        .ext_irq_event (ext_event),
        .portb_change  (portb_event),
        .peri_cond     (peri_cond),
        .rb            (rb.core),
        .irq_req       (irq_req)
    );

    // Bus decode
    logic [8:0] idx;
    logic       lane0;
    logic       sel_ics;
    logic       sel_pie;
    logic       sel_pflag;
    logic       sel_st;
    logic       sel_msk;
    logic       addr_ok;
    logic       wr_go;
    logic       rd_go;
    logic       ack_reg;

    assign idx     = avs_address[10:2];
    assign lane0   = (avs_address[1:0] == 2'h0) & avs_byteenable[0];
    assign sel_ics = (avs_address[1:0] == 2'h0) &
                     ((idx == cpie_pkg::IDX_ICS_B0) | (idx == cpie_pkg::IDX_ICS_B1) |
                      (idx == cpie_pkg::IDX_ICS_B2) | (idx == cpie_pkg::IDX_ICS_B3));
    assign sel_pie   = (avs_address[1:0] == 2'h0) & (idx == cpie_pkg::IDX_PIE);
    assign sel_pflag = (avs_address[1:0] == 2'h0) & (idx == cpie_pkg::IDX_PFLAG);
    assign sel_st    = (avs_address[1:0] == 2'h0) & (idx == cpie_pkg::IDX_IRQ_ST);
    assign sel_msk   = (avs_address[1:0] == 2'h0) & (idx == cpie_pkg::IDX_IRQ_MSK);
    assign addr_ok   = sel_ics | sel_pie | sel_pflag | sel_st | sel_msk;

    // One wait state: answer on the edge after the request is seen
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign wr_go = avs_write & ack_reg;
    assign rd_go = avs_read & ~ack_reg;

    assign rb.wr_ics   = wr_go & sel_ics & lane0;
    assign rb.wr_pie   = wr_go & sel_pie & lane0;
    assign rb.wr_pflag = wr_go & sel_pflag & lane0;
    assign rb.wdata    = avs_writedata[7:0];

    // Block event status, write one to clear; mask gates irq
    logic [1:0] irq_st_reg;
    logic [1:0] irq_st_next;
    logic [1:0] irq_msk_reg;
    logic [1:0] ev;
    logic [1:0] st_clr;

    assign ev          = {rb.peri_event, rb.core_event};
    assign st_clr      = (wr_go & sel_st & lane0) ? avs_writedata[1:0] : 2'h0;
    assign irq_st_next = (irq_st_reg & ~st_clr) | ev;
    assign irq         = |(irq_st_reg & irq_msk_reg);

    logic [31:0] rd_mux;
    assign rd_mux = sel_ics   ? {24'h000000, rb.ics} :
                    sel_pie   ? {24'h000000, rb.pie} :
                    sel_pflag ? {24'h000000, rb.pflag} :
                    sel_st    ? {30'h00000000, irq_st_reg} :
                    sel_msk   ? {30'h00000000, irq_msk_reg} :
                    cpie_pkg::RD_UNMAPPED;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ack_reg      <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            irq_st_reg   <= cpie_pkg::IRQ_RESET;
            irq_msk_reg  <= cpie_pkg::IRQ_RESET;
        end else begin
            ack_reg    <= (avs_read | avs_write) & ~ack_reg;
            irq_st_reg <= irq_st_next;
            if (rd_go) begin
                avs_readdata <= addr_ok ? rd_mux : cpie_pkg::RD_UNMAPPED;
            end
            if (wr_go & sel_msk & lane0) begin
                irq_msk_reg <= avs_writedata[1:0];
            end
        end
    end
endmodule
`default_nettype wire

/* cpie_chk.sv */
// Port-level checker for cpie_top, bound below.
// Assumes one clk_sys domain and a one-wait-state register bus.
`timescale 1ns/1ps
`default_nettype none
module cpie_chk (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic [10:0] avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        timer0_ovf,
    input wire logic [7:0]  peri_cond,
    input wire logic        irq_req,
    input wire logic        irq
);
    logic [7:0] ics_reg;
    logic [7:0] pie_reg;
    wire        done   = !avs_waitrequest;
    wire        wr_any = avs_write && done;
    wire        wr_ok  = wr_any && avs_byteenable[0];
    wire        at_ics = avs_address[8:0] == 9'h02c;
    wire        at_pie = avs_address == 11'h230;
    // Shadow of the enable bits, changed only by writes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ics_reg <= 8'h00;
            pie_reg <= 8'h00;
        end else begin
            if (wr_ok && at_ics) ics_reg <= avs_writedata[7:0];
            if (wr_ok && at_pie) pie_reg <= avs_writedata[7:0];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    AST_WAIT_FIRST:
        assert property ($rose(avs_read || avs_write) |-> avs_waitrequest) else $error("no wait");
    AST_ONE_WAIT:
        assert property ((avs_read || avs_write) && avs_waitrequest |=> done)
        else $error("second wait state");
    AST_GIE_BLOCK:
        assert property (!ics_reg[7] |-> !irq_req) else $error("request without global enable");
    AST_T0_REQ:
        assert property (timer0_ovf && ics_reg[7] && ics_reg[5] && !wr_any |=> irq_req)
        else $error("timer0 event gave no request");
    AST_PERI_REQ:
        assert property ((|(peri_cond & pie_reg)) && ics_reg[7] && ics_reg[6] && !wr_any
            |=> irq_req) else $error("peripheral event gave no request");
    AST_REQ_HOLD:
        assert property (irq_req && !wr_any |=> irq_req) else $error("request dropped alone");
    AST_IRQ_HOLD:
        assert property (irq && !wr_any |=> irq) else $error("irq dropped alone");
    AST_PIE_RD:
        assert property (avs_read && done && at_pie |=> avs_readdata == {24'h0, pie_reg})
        else $error("enable register read wrong");
    AST_ICS_RD:
        assert property (avs_read && done && at_ics |=> avs_readdata[7:3] == ics_reg[7:3])
        else $error("control register read wrong");
    cover property ($rose(irq_req));
    cover property ($rose(irq));
    cover property (avs_read && done && at_pie);
endmodule
bind cpie_top cpie_chk u_chk (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .timer0_ovf,
    .peri_cond, .irq_req, .irq);
`default_nettype wire

/* cpie_evt_src.sv */
// Event sources: timer0, peripheral lines and the external pins.
// Assumes calls start just after a rising clk_sys edge.
`timescale 1ns/1ps
`default_nettype none
module cpie_evt_src (
    input  wire logic  clk_sys,
    output logic       timer0_ovf,
    output logic       ext_irq_pin,
    output logic [3:0] portb_upper_pins,
    output logic [7:0] peri_cond
);
    initial begin
        timer0_ovf = 1'b0;
        ext_irq_pin = 1'b0;
        portb_upper_pins = 4'h0;
        peri_cond = 8'h00;
    end
    // One-cycle event, then let the flags settle
    task automatic pulse(input logic t0, input logic [7:0] pc);
        timer0_ovf <= t0;
        peri_cond  <= pc;
        @(posedge clk_sys);
        timer0_ovf <= 1'b0;
        peri_cond  <= 8'h00;
        @(posedge clk_sys);
    endtask
    task automatic pins(input logic e, input logic [3:0] p);
        ext_irq_pin      <= e;
        portb_upper_pins <= p;
        repeat (5) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

/* tb_core_and_peripheral_irq_enables.sv */
// Self-checking bench for cpie_top with event-source model.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
module tb_core_and_peripheral_irq_enables;
    localparam logic [10:0] A_ICS = 11'h02c;
    localparam logic [10:0] A_PIE = 11'h230;
    localparam logic [10:0] A_PFL = 11'h7c0;
    localparam logic [10:0] A_ST  = 11'h7c4;
    localparam logic [10:0] A_MSK = 11'h7c8;
    logic        clk_sys, rst, avs_read, avs_write, avs_waitrequest;
    logic        timer0_ovf, ext_irq_pin, ext_irq_rising, irq_req, irq;
    logic [10:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable, portb_upper_pins;
    logic [7:0]  peri_cond;
    logic [10:0] ics_a [4] = '{11'h02c, 11'h22c, 11'h42c, 11'h62c};
    int          num_errors = 0;
    int          comparisons = 0;
    cpie_top dut (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .timer0_ovf, .ext_irq_pin,
        .ext_irq_rising, .portb_upper_pins, .peri_cond, .irq_req, .irq);
    cpie_evt_src src (.clk_sys, .timer0_ovf, .ext_irq_pin, .portb_upper_pins, .peri_cond);
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [10:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        int n = 0;
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= !w;
        avs_writedata <= {24'h0, d};
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            check("bus wait", 32'h1, 32'h0);
            end_of_test();
        end
        // Read data taken at the edge that ends the wait
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input string what, input logic [10:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        check(what, q, e);
    endtask
    task automatic t_regs;
        rd("ics reset", A_ICS, 32'h0);
        rd("pie reset", A_PIE, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(ics_a[i], 8'h0f << i);
            rd("ics mirror", ics_a[(i + 1) % 4], 32'h0f << i);
        end
        wr(A_ICS, 8'h00);
        wr(A_PIE, 8'ha5);
        avs_byteenable <= 4'he;
        wr(A_PIE, 8'h5a);
        avs_byteenable <= 4'hf;
        wr(11'h004, 8'hff);
        rd("pie kept", A_PIE, 32'ha5);
        rd("unmapped", 11'h004, 32'h0);
    endtask
    task automatic t_t0;
        src.pulse(1'b1, 8'h00);
        rd("t0 flag", A_ICS, 32'h04);
        wr(A_ICS, 8'h24);
        check("req no gie", irq_req, 32'h0);
        wr(A_ICS, 8'ha4);
        check("req t0", irq_req, 32'h1);
        rd("core status", A_ST, 32'h1);
        check("irq masked", irq, 32'h0);
        wr(A_MSK, 8'h01);
        check("irq open", irq, 32'h1);
        wr(A_ST, 8'h01);
        check("irq cleared", irq, 32'h0);
        wr(A_ICS, 8'ha0);
        check("req cleared", irq_req, 32'h0);
        wr(A_ICS, 8'h00);
    endtask
    task automatic t_pins;
        src.pins(1'b1, 4'h0);
        rd("ext rise", A_ICS, 32'h02);
        rd("ext held", A_ICS, 32'h02);
        wr(A_ICS, 8'h00);
        ext_irq_rising <= 1'b0;
        src.pins(1'b0, 4'h0);
        rd("ext fall", A_ICS, 32'h02);
        wr(A_ICS, 8'h00);
        src.pins(1'b0, 4'h8);
        rd("port change", A_ICS, 32'h01);
        wr(A_ICS, 8'h00);
    endtask
    task automatic t_peri;
        for (int i = 0; i < 8; i++) begin
            wr(A_ICS, 8'hc0);
            wr(A_PIE, 8'h01 << i);
            src.pulse(1'b0, ~(8'h01 << i));
            check("peri other", irq_req, 32'h0);
            wr(A_ICS, 8'h80);
            src.pulse(1'b0, 8'h01 << i);
            check("peri no group", irq_req, 32'h0);
            wr(A_ICS, 8'hc0);
            check("peri req", irq_req, 32'h1);
            wr(A_PFL, 8'h00);
            check("peri cleared", irq_req, 32'h0);
        end
        // Parallel port enable cleared again with all the others at the end
        wr(A_PIE, 8'h00);
        rd("psp enable clear", A_PIE, 32'h0);
    endtask
    initial begin
        rst = 1'b1;
        avs_address = 11'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        ext_irq_rising = 1'b1;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_regs();
        t_t0();
        t_pins();
        t_peri();
        end_of_test();
    end
endmodule
`default_nettype wire
